// File: toa_pkg.sv
// package for the thermal overload accumulator
package toa_pkg;
  // apb register offsets
  localparam logic [7:0] OFF_LEVEL1 = 8'h00;
  localparam logic [7:0] OFF_LEVEL2 = 8'h04;
  localparam logic [7:0] OFF_CURVE = 8'h08;
  localparam logic [7:0] OFF_COOL = 8'h0c;
  localparam logic [7:0] OFF_LINTIME = 8'h10;
  localparam logic [7:0] OFF_TCONST = 8'h14;
  localparam logic [7:0] OFF_FREEF = 8'h18;
  localparam logic [7:0] OFF_FREEI = 8'h1c;
  localparam logic [7:0] OFF_CTRL = 8'h20;
  localparam logic [7:0] OFF_STAT = 8'h24;
  localparam logic [7:0] OFF_MASK = 8'h28;
  localparam logic [7:0] OFF_ACCUM = 8'h2c;
  localparam logic [7:0] OFF_INVACC = 8'h30;
  localparam logic [7:0] OFF_FAULT = 8'h34;
  // accumulator full scale (100%)
  localparam logic [31:0] ACC_FULL = 32'h0100_0000;
  // error codes
  localparam logic [7:0] MOTOR_OVERLOAD_ERROR = 8'h05;
  localparam logic [7:0] INVERTER_OVERLOAD_ERROR = 8'h26;
  // curve codes
  localparam logic [1:0] CURVE_REDUCED = 2'h0;
  localparam logic [1:0] CURVE_CONST = 2'h1;
  localparam logic [1:0] CURVE_FREE = 2'h2;
  // free frequency limit, 0.01 Hz units
  localparam logic [15:0] FREQ_MAX = 16'h9c40;
  // time steps in cycles at 200 MHz
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 10000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int RESET_LOCK_S = 10;
  localparam int RESET_LOCK_TICKS = RESET_LOCK_S * 1000000 / TICK_US;
  localparam int CYCLE_MIN = 10;
  localparam int CYCLE_TICKS = CYCLE_MIN * 60 * 1000000 / TICK_US;
  // linear cooling time in 0.01 s units per tick of 10 ms
  localparam logic [31:0] LINTIME_DEF = 32'd60000;
  localparam logic [31:0] TCONST_DEF = 32'd15000;
  localparam logic [31:0] LINTIME_MIN = 32'd10;
  localparam logic [31:0] LINTIME_MAX = 32'd10000000;
  typedef enum logic [1:0] {COOL_OFF, COOL_FIXED, COOL_LIN, COOL_TC} toa_cool_t;
  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] curr;
  } toa_meas_t;
endpackage

// File: toa_thermal_overload_accumulator.sv
// thermal overload accumulator with apb registers
// Functional notes
// - level clamped to 20..100 percent rated
// - full accumulator trips with motor error
// - output forced off while tripped
// - separate inverter model with own error
// - inverter model constant torque, rated level
// - curve select chooses frequency reduction
// - free points bounded by next, 400 Hz
// - mode 00 integrates overload proportionally
// - mode 00 uses inverter cooling model
// - reset rejected within 10 s of trip
// - mode 00 clears per 10 min cycle
// - mode 01 cools 100 percent per 10 min
// - mode 02 cools at linear cooling time
// - mode 03 decays by time constant
// - trips at 115 percent of level
// - base curve from duty rating input
// - second motor level and curve set
`timescale 1ns/1ps
module toa_thermal_overload_accumulator #(
  parameter int TICK_CYCLES = toa_pkg::TICK_CYC,
  parameter logic [15:0] RATED_CURRENT = 16'd1000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire toa_pkg::toa_meas_t meas,
  input wire logic secondMotor,
  input wire logic heavyDuty,
  output logic outputOff,
  output logic tripPulse,
  output logic [7:0] errorCode,
  output logic irq
);
  logic rs1Q, rstnQ;
  logic [15:0] level1Q, level2Q;
  logic [1:0] curve1Q, curve2Q;
  toa_pkg::toa_cool_t coolQ;
  logic [31:0] linTimeQ, tConstQ;
  logic [47:0] freeFQ, freeIQ;
  logic [31:0] accQ, invAccQ;
  logic tripQ;
  logic [31:0] tickCntQ;
  logic tickQ;
  logic [15:0] lockQ;
  logic [19:0] cycleQ;
  logic [1:0] statQ, maskQ;
  logic [7:0] faultQ [4];
  logic [15:0] divCntQ;
  logic rstCmd;
  logic apbWr, apbRd;
  logic [15:0] level, effLevel, invLevel;
  logic [1:0] curve;
  logic [31:0] motInc, invInc, coolDec;
  logic motTrip, invTrip;

  // limit a level setting to 20..100 percent of rated
  function automatic logic [15:0] clampLevel(input logic [15:0] v);
    logic [15:0] lo;
    lo = 16'((32'(RATED_CURRENT) * 32'd20) / 32'd100);
    if (v < lo) clampLevel = lo;
    else if (v > RATED_CURRENT) clampLevel = RATED_CURRENT;
    else clampLevel = v;
  endfunction

  // overload increment per tick, scaled by excess current
  function automatic logic [31:0] overInc(input logic [15:0] cur, input logic [15:0] lvl, input logic hd);
    logic [31:0] trip;
    trip = (32'(lvl) * 32'd115) / 32'd100;
    if (cur <= trip || lvl == 16'h0) overInc = 32'h0;
    else overInc = 32'(((64'(cur - 16'(trip)) * 64'(toa_pkg::ACC_FULL)) / 64'(lvl)) >> (hd ? 6 : 7));
  endfunction

  // saturating accumulate between 0 and full scale
  function automatic logic [31:0] satAcc(input logic [31:0] a, input logic [31:0] inc, input logic [31:0] dec);
    logic [32:0] s;
    s = 33'(a) + 33'(inc);
    if (s > 33'(toa_pkg::ACC_FULL)) s = 33'(toa_pkg::ACC_FULL);
    if (s < 33'(dec)) satAcc = 32'h0;
    else satAcc = 32'(s - 33'(dec));
  endfunction

  // reset synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs1Q <= 1'b0;
      rstnQ <= 1'b0;
    end else begin
      rs1Q <= 1'b1;
      rstnQ <= rs1Q;
    end
  end

  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && penable && !pwrite;
  assign rstCmd = apbWr && paddr == toa_pkg::OFF_CTRL && pwdata[0];

  assign level = clampLevel(secondMotor ? level2Q : level1Q);
  assign curve = secondMotor ? curve2Q : curve1Q;

  always_comb begin
    effLevel = level;
    case (curve)
      toa_pkg::CURVE_REDUCED: begin
        if (meas.freq < 16'd2000) effLevel = 16'((32'(level) * 32'd80) / 32'd100);
      end
      toa_pkg::CURVE_CONST: effLevel = level;
      toa_pkg::CURVE_FREE: begin
        if (meas.freq <= freeFQ[15:0]) effLevel = freeIQ[15:0];
        else if (meas.freq <= freeFQ[31:16]) effLevel = freeIQ[31:16];
        else effLevel = freeIQ[47:32];
        if (effLevel == 16'h0) effLevel = level;
      end
      default: effLevel = level;
    endcase
  end

  assign invLevel = RATED_CURRENT;
  // trip at 115 percent of the level
  assign motInc = overInc(meas.curr, effLevel, heavyDuty);
  assign invInc = overInc(meas.curr, invLevel, 1'b1);
  assign motTrip = accQ >= toa_pkg::ACC_FULL;
  assign invTrip = invAccQ >= toa_pkg::ACC_FULL;

  // cooling decrement per tick
  always_comb begin
    coolDec = 32'h0;
    case (coolQ)
      // fixed 100 percent per 10 minutes
      toa_pkg::COOL_FIXED: coolDec = toa_pkg::ACC_FULL / 32'(toa_pkg::CYCLE_TICKS);
      toa_pkg::COOL_LIN: coolDec = toa_pkg::ACC_FULL / linTimeQ;
      toa_pkg::COOL_TC: coolDec = 32'((64'(accQ) + 64'(tConstQ) - 64'h1) / 64'(tConstQ));
      default: coolDec = 32'h0;
    endcase
    if (motInc != 32'h0) coolDec = 32'h0;
  end

  // tick generator
  always_ff @(posedge clk or negedge rstnQ) begin
    if (!rstnQ) begin
      tickCntQ <= 32'h0;
      tickQ <= 1'b0;
    end else begin
      tickQ <= tickCntQ == 32'(TICK_CYCLES - 1);
      tickCntQ <= (tickCntQ == 32'(TICK_CYCLES - 1)) ? 32'h0 : tickCntQ + 32'h1;
    end
  end

  // mode 00 shares the inverter model cycle
  always_ff @(posedge clk or negedge rstnQ) begin
    if (!rstnQ) cycleQ <= 20'h0;
    else if (tickQ) cycleQ <= (cycleQ == 20'(toa_pkg::CYCLE_TICKS - 1)) ? 20'h0 : cycleQ + 20'h1;
  end

  // motor accumulator
  always_ff @(posedge clk or negedge rstnQ) begin
    if (!rstnQ) accQ <= 32'h0;
    else if (rstCmd && lockQ == 16'h0) accQ <= 32'h0;
    else if (tickQ) begin
      if (coolQ == toa_pkg::COOL_OFF && cycleQ == 20'(toa_pkg::CYCLE_TICKS - 1) && !tripQ) accQ <= 32'h0;
      else accQ <= satAcc(accQ, motInc, coolDec);
    end
  end

  always_ff @(posedge clk or negedge rstnQ) begin
    if (!rstnQ) invAccQ <= 32'h0;
    else if (rstCmd && lockQ == 16'h0) invAccQ <= 32'h0;
    else if (tickQ) begin
      if (cycleQ == 20'(toa_pkg::CYCLE_TICKS - 1) && !tripQ) invAccQ <= 32'h0;
      else invAccQ <= satAcc(invAccQ, invInc, 32'h0);
    end
  end

  always_ff @(posedge clk or negedge rstnQ) begin
    if (!rstnQ) begin
      tripQ <= 1'b0;
      errorCode <= 8'h0;
      lockQ <= 16'h0;
      tripPulse <= 1'b0;
    end else begin
      tripPulse <= 1'b0;
      if (!tripQ && (motTrip || invTrip)) begin
        tripQ <= 1'b1;
        tripPulse <= 1'b1;
        errorCode <= motTrip ? toa_pkg::MOTOR_OVERLOAD_ERROR : toa_pkg::INVERTER_OVERLOAD_ERROR;
        lockQ <= 16'(toa_pkg::RESET_LOCK_TICKS);
      end else if (rstCmd && lockQ == 16'h0) begin
        tripQ <= 1'b0;
        errorCode <= 8'h0;
      end else if (tickQ && lockQ != 16'h0) begin
        lockQ <= lockQ - 16'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstnQ) begin
    if (!rstnQ) outputOff <= 1'b0;
    else outputOff <= tripQ || motTrip || invTrip;
  end

  // fault history, newest first
  always_ff @(posedge clk or negedge rstnQ) begin
    if (!rstnQ) begin
      for (int i = 0; i < 4; i++) faultQ[i] <= 8'h0;
    end else if (!tripQ && (motTrip || invTrip)) begin
      faultQ[0] <= motTrip ? toa_pkg::MOTOR_OVERLOAD_ERROR : toa_pkg::INVERTER_OVERLOAD_ERROR;
      for (int i = 1; i < 4; i++) faultQ[i] <= faultQ[i - 1];
    end
  end

  // sticky status, set wins over read clear
  always_ff @(posedge clk or negedge rstnQ) begin
    if (!rstnQ) statQ <= 2'h0;
    else begin
      logic [1:0] setv;
      setv = {(!tripQ && invTrip && !motTrip), (!tripQ && motTrip)};
      if (apbRd && paddr == toa_pkg::OFF_STAT) statQ <= setv;
      else statQ <= statQ | setv;
    end
  end

  always_ff @(posedge clk or negedge rstnQ) begin
    if (!rstnQ) irq <= 1'b0;
    else irq <= |(statQ & maskQ);
  end

  // configuration registers
  always_ff @(posedge clk or negedge rstnQ) begin
    if (!rstnQ) begin
      level1Q <= RATED_CURRENT;
      level2Q <= RATED_CURRENT;
      curve1Q <= toa_pkg::CURVE_REDUCED;
      curve2Q <= toa_pkg::CURVE_REDUCED;
      coolQ <= toa_pkg::COOL_OFF;
      linTimeQ <= toa_pkg::LINTIME_DEF;
      tConstQ <= toa_pkg::TCONST_DEF;
      freeFQ <= 48'h0;
      freeIQ <= 48'h0;
      maskQ <= 2'h0;
    end else if (apbWr) begin
      case (paddr)
        toa_pkg::OFF_LEVEL1: level1Q <= clampLevel(pwdata[15:0]);
        toa_pkg::OFF_LEVEL2: level2Q <= clampLevel(pwdata[15:0]);
        toa_pkg::OFF_CURVE: begin
          if (pwdata[1:0] != 2'h3) curve1Q <= pwdata[1:0];
          if (pwdata[9:8] != 2'h3) curve2Q <= pwdata[9:8];
        end
        toa_pkg::OFF_COOL: coolQ <= toa_pkg::toa_cool_t'(pwdata[1:0]);
        toa_pkg::OFF_LINTIME: begin
          if (pwdata >= toa_pkg::LINTIME_MIN && pwdata <= toa_pkg::LINTIME_MAX) linTimeQ <= pwdata;
        end
        toa_pkg::OFF_TCONST: begin
          if (pwdata >= toa_pkg::LINTIME_MIN && pwdata <= toa_pkg::LINTIME_MAX) tConstQ <= pwdata;
        end
        // point index in bits 17:16, bounded frequency
        toa_pkg::OFF_FREEF: begin
          case (pwdata[17:16])
            2'h0: freeFQ[15:0] <= (pwdata[15:0] > freeFQ[31:16]) ? freeFQ[31:16] : pwdata[15:0];
            2'h1: freeFQ[31:16] <= (pwdata[15:0] > freeFQ[47:32]) ? freeFQ[47:32] : pwdata[15:0];
            2'h2: freeFQ[47:32] <= (pwdata[15:0] > toa_pkg::FREQ_MAX) ? toa_pkg::FREQ_MAX : pwdata[15:0];
            default: freeFQ <= freeFQ;
          endcase
        end
        toa_pkg::OFF_FREEI: begin
          case (pwdata[17:16])
            2'h0: freeIQ[15:0] <= (pwdata[15:0] > RATED_CURRENT) ? RATED_CURRENT : pwdata[15:0];
            2'h1: freeIQ[31:16] <= (pwdata[15:0] > RATED_CURRENT) ? RATED_CURRENT : pwdata[15:0];
            2'h2: freeIQ[47:32] <= (pwdata[15:0] > RATED_CURRENT) ? RATED_CURRENT : pwdata[15:0];
            default: freeIQ <= freeIQ;
          endcase
        end
        toa_pkg::OFF_MASK: maskQ <= pwdata[1:0];
        default: maskQ <= maskQ;
      endcase
    end
  end

  // apb read data and response, zero wait
  always_ff @(posedge clk or negedge rstnQ) begin
    if (!rstnQ) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > toa_pkg::OFF_FAULT || paddr[1:0] != 2'h0);
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          toa_pkg::OFF_LEVEL1: prdata <= {16'h0, level1Q};
          toa_pkg::OFF_LEVEL2: prdata <= {16'h0, level2Q};
          toa_pkg::OFF_CURVE: prdata <= {22'h0, curve2Q, 6'h0, curve1Q};
          toa_pkg::OFF_COOL: prdata <= {30'h0, coolQ};
          toa_pkg::OFF_LINTIME: prdata <= linTimeQ;
          toa_pkg::OFF_TCONST: prdata <= tConstQ;
          toa_pkg::OFF_CTRL: prdata <= {15'h0, tripQ, lockQ};
          toa_pkg::OFF_STAT: prdata <= {30'h0, statQ};
          toa_pkg::OFF_MASK: prdata <= {30'h0, maskQ};
          toa_pkg::OFF_ACCUM: prdata <= accQ;
          toa_pkg::OFF_INVACC: prdata <= invAccQ;
          toa_pkg::OFF_FAULT: prdata <= {faultQ[3], faultQ[2], faultQ[1], faultQ[0]};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

// File: toa_thermal_overload_accumulator_sva.sv
// port assertions for the thermal overload accumulator
`timescale 1ns/1ps
module toa_thermal_overload_accumulator_sva #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic outputOff,
  input wire logic tripPulse,
  input wire logic [7:0] errorCode
);
  localparam int LOCKC = (toa_pkg::RESET_LOCK_TICKS - 1) * TICK_CYCLES;
  logic ctrlWr;
  int sinceTrip;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // control register write strobe, any write data
  assign ctrlWr = psel && penable && pwrite && (paddr == toa_pkg::OFF_CTRL);
  // cycles since last trip entry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sinceTrip <= 0;
    end else if (tripPulse) begin
      sinceTrip <= 0;
    end else if (sinceTrip < LOCKC) begin
      sinceTrip <= sinceTrip + 1;
    end
  end
  chk_trip_off: assert property (tripPulse |-> ##[0:1] outputOff)
    else $error("output not off after trip");
  chk_off_cause: assert property ($rose(outputOff) |-> tripPulse || $past(tripPulse))
    else $error("output off without trip");
  chk_off_release: assert property ($fell(outputOff) |-> $past(ctrlWr) || $past(ctrlWr, 2))
    else $error("output released without reset command");
  chk_lock_time: assert property ($fell(outputOff) |-> sinceTrip >= LOCKC)
    else $error("trip cleared inside lockout");
  chk_trip_code: assert property (tripPulse |-> ##[0:1] (errorCode == toa_pkg::MOTOR_OVERLOAD_ERROR ||
    errorCode == toa_pkg::INVERTER_OVERLOAD_ERROR))
    else $error("trip without overload code");
  chk_code_legal: assert property (errorCode == 8'h00 || errorCode == toa_pkg::MOTOR_OVERLOAD_ERROR ||
    errorCode == toa_pkg::INVERTER_OVERLOAD_ERROR)
    else $error("unknown error code");
  chk_pulse_once: assert property (tripPulse |=> !tripPulse)
    else $error("trip pulse too long");
  chk_ready_access: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  cov_trip: cover property (tripPulse);
  cov_clear: cover property ($fell(outputOff));
  cov_ctrl: cover property (ctrlWr && outputOff);
endmodule
bind toa_thermal_overload_accumulator toa_thermal_overload_accumulator_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .outputOff(outputOff), .tripPulse(tripPulse), .errorCode(errorCode));

// File: toa_drive_model.sv
// output stage and current sensing model
`timescale 1ns/1ps
module toa_drive_model (
  input wire logic clk,
  input wire logic outputOff,
  input wire logic [15:0] demandFreq,
  input wire logic [15:0] demandCurr,
  output toa_pkg::toa_meas_t meas
);
  initial meas = '0;
  // stage off gives no current and no frequency
  always @(posedge clk) begin
    meas <= outputOff ? '0 : {demandFreq, demandCurr};
  end
endmodule

// File: toa_thermal_overload_accumulator_tb.sv
// self-checking bench for the thermal overload accumulator
`timescale 1ns/1ps
module toa_thermal_overload_accumulator_tb;
  localparam int TK = 20;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  toa_pkg::toa_meas_t meas;
  logic heavyDuty = 1'b0;
  logic secondMotor = 1'b0;
  logic outputOff;
  logic tripPulse;
  logic [7:0] errorCode;
  logic irq;
  logic [15:0] demandFreq = 16'h1388;
  logic [15:0] demandCurr = 16'h0064;
  logic [31:0] rd;
  logic [31:0] a;
  logic er;
  int n_errors = 0;
  int total_checks = 0;
  always #2.5 clk = ~clk;
  toa_thermal_overload_accumulator #(.TICK_CYCLES(TK)) i_dut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
    .secondMotor(secondMotor), .heavyDuty(heavyDuty), .outputOff(outputOff), .tripPulse(tripPulse),
    .errorCode(errorCode), .irq(irq));
  toa_drive_model i_drive (.clk(clk), .outputOff(outputOff), .demandFreq(demandFreq),
    .demandCurr(demandCurr), .meas(meas));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, waits for ready
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (i = 0; pready !== 1'b1 && i < 20; i++) @(posedge clk);
    if (i == 20) begin
      n_errors++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask
  initial begin
    int m;
    int i;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, outputOff}, 32'h0);
    rdchk(toa_pkg::OFF_ACCUM, 32'h0);
    rdchk(toa_pkg::OFF_FAULT, 32'h0);
    // level clamps and second set
    wr(toa_pkg::OFF_LEVEL1, 32'h32);
    rdchk(toa_pkg::OFF_LEVEL1, 32'hc8);
    wr(toa_pkg::OFF_LEVEL2, 32'h1388);
    rdchk(toa_pkg::OFF_LEVEL2, 32'h3e8);
    rdchk(toa_pkg::OFF_LEVEL1, 32'hc8);
    for (m = 0; m < 4; m++) begin
      wr(toa_pkg::OFF_CURVE, m);
      rdchk(toa_pkg::OFF_CURVE, (m == 3) ? 32'h2 : m);
    end
    wr(toa_pkg::OFF_CURVE, 32'h1);
    wr(toa_pkg::OFF_LINTIME, 32'h5);
    rdchk(toa_pkg::OFF_LINTIME, toa_pkg::LINTIME_DEF);
    wr(toa_pkg::OFF_LINTIME, 32'h64);
    rdchk(toa_pkg::OFF_LINTIME, 32'h64);
    wr(toa_pkg::OFF_TCONST, 32'ha);
    apb(1'b0, 8'h38, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(toa_pkg::OFF_MASK, 32'h1);
    // heat then cool in modes 03 to 01, heat then hold in mode 00, ending in mode 00
    for (m = 3; m >= 0; m--) begin
      wr(toa_pkg::OFF_COOL, m);
      demandCurr <= 16'h044c;
      repeat (10 * TK) @(posedge clk);
      demandCurr <= 16'h0064;
      repeat (2 * TK) @(posedge clk);
      apb(1'b0, toa_pkg::OFF_ACCUM, 32'h0);
      a = rd;
      repeat (20 * TK) @(posedge clk);
      apb(1'b0, toa_pkg::OFF_ACCUM, 32'h0);
      chk({31'h0, (m == 0) ? rd == a : rd < a}, 32'h1);
    end
    // second set at rated level sees no overload at this current
    secondMotor <= 1'b1;
    demandCurr <= 16'h044c;
    apb(1'b0, toa_pkg::OFF_ACCUM, 32'h0);
    a = rd;
    repeat (5 * TK) @(posedge clk);
    rdchk(toa_pkg::OFF_ACCUM, a);
    secondMotor <= 1'b0;
    heavyDuty <= 1'b1;
    for (i = 0; tripPulse !== 1'b1 && i < 60000; i++) @(posedge clk);
    chk({31'h0, i < 60000}, 32'h1);
    @(posedge clk);
    chk({31'h0, outputOff}, 32'h1);
    chk({24'h0, errorCode}, {24'h0, toa_pkg::MOTOR_OVERLOAD_ERROR});
    rdchk(toa_pkg::OFF_ACCUM, toa_pkg::ACC_FULL);
    rdchk(toa_pkg::OFF_FAULT, {24'h0, toa_pkg::MOTOR_OVERLOAD_ERROR});
    chk({31'h0, irq}, 32'h1);
    rdchk(toa_pkg::OFF_STAT, 32'h1);
    rdchk(toa_pkg::OFF_STAT, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    demandCurr <= 16'h0064;
    wr(toa_pkg::OFF_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, outputOff}, 32'h1);
    apb(1'b0, toa_pkg::OFF_CTRL, 32'h0);
    chk({31'h0, rd[16]}, 32'h1);
    repeat (1000 * TK) @(posedge clk);
    wr(toa_pkg::OFF_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, outputOff}, 32'h0);
    rdchk(toa_pkg::OFF_ACCUM, 32'h0);
    report_and_stop();
  end
endmodule
